// [hw/eac_regs.svh]
// register map, field positions, reset values and timing counts of the nonvolatile access controller
`ifndef EAC_REGS_SVH
`define EAC_REGS_SVH

`define EAC_IO_TOP 8'h3f
`define EAC_DATA_SPACE_OFFSET 8'h20
`define EAC_DATA_SPACE_TOP 8'h5f
`define EAC_BIT_ACCESS_TOP 6'h1f

`define EAC_OFF_ADDR_LOW 6'h21
`define EAC_OFF_ADDR_HIGH 6'h22
`define EAC_OFF_DATA 6'h20
`define EAC_OFF_CONTROL 6'h1f
`define EAC_OFF_STATUS 6'h1d
`define EAC_OFF_GPIO0 6'h1e
`define EAC_OFF_GPIO1 6'h2a
`define EAC_OFF_GPIO2 6'h2b

`define EAC_CTL_READY_IRQ_ENABLE 3
`define EAC_CTL_MASTER_WRITE_ARM 2
`define EAC_CTL_WRITE_STROBE 1
`define EAC_CTL_READ_STROBE 0
`define EAC_STAT_WRITE_DONE 0

`define EAC_RESET_BYTE 8'h00
`define EAC_ARM_CYCLES 3'd4
`define EAC_WRITE_STALL_CYCLES 3'd2
`define EAC_READ_STALL_CYCLES 3'd4
`define EAC_WRITE_TICKS 27072
`define EAC_WRITE_TIME_US 3400

`endif

// [hw/eac_pkg.sv]
// types shared by the nonvolatile access controller
package eac_pkg;
  typedef enum logic [1:0] {
    EAC_IDLE = 2'b01,
    EAC_PROG = 2'b10
  } eac_state_type;
endpackage

// [hw/eac_mem.sv]
// byte array of the nonvolatile store, registered read data
`timescale 1ns/100ps
module eac_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2048,
  parameter int AW = 11
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  localparam int IW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  wire logic [IW-1:0] index = addr[IW-1:0];

  always_ff @(posedge mclk) begin
    if (ce && we) begin
      store[index] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && re) begin
      rdata <= store[index];
    end
  end
endmodule

// [hw/eac_top.sv]
// nonvolatile access controller: io register port, write unlock, timed programming
// Behaviour
// - io addresses 0x00-0x3f, data space adds 0x20
// - bit ops below 0x20 touch only that bit
// - status flags clear by writing one
// - unused address and control bits read zero
// - eleven-bit linear byte address
// - address register undefined after reset
// - data register holds write byte, read result
// - ready irq while enabled and no write
// - master arm self-clears after four cycles
// - write strobe starts write only while armed
// - no write while flash self-programming
// - write strobe stays set until done
// - write start stalls processor two cycles
// - read fetches byte, stalls four cycles
// - no reads or address change during write
// - write lasts 27072 oscillator cycles
// - three general storage registers, low bit-accessible
// - write in progress survives system reset
`timescale 1ns/100ps
`include "eac_regs.svh"
module eac_top import eac_pkg::*; #(
  parameter int ADDR_W = 11,
  parameter int DEPTH = 2048,
  parameter int WRITE_TICKS = `EAC_WRITE_TICKS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic npor,
  input wire logic ce,
  input wire logic io_space,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_bit_set,
  input wire logic io_bit_clr,
  input wire logic [2:0] io_bit,
  input wire logic [7:0] io_wdata,
  input wire logic gie,
  input wire logic self_program_busy,
  input wire logic rc_clk,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic ready_irq,
  output logic write_busy
);
  localparam int TW = $clog2(WRITE_TICKS + 1);

  // returns {valid, io index}
  function automatic logic [6:0] io_decode(input logic space, input logic [7:0] a);
    logic [7:0] rel;
    rel = a - `EAC_DATA_SPACE_OFFSET;
    if (space) begin
      io_decode = {a <= `EAC_IO_TOP, a[5:0]};
    end else begin
      io_decode = {(a >= `EAC_DATA_SPACE_OFFSET) && (a <= `EAC_DATA_SPACE_TOP), rel[5:0]};
    end
  endfunction

  // value a write leaves in a plain storage byte
  function automatic logic [7:0] write_value(input logic [7:0] cur, input logic bitop, input logic set,
                                             input logic [7:0] mask, input logic [7:0] wdata);
    if (!bitop) begin
      write_value = wdata;
    end else if (set) begin
      write_value = cur | mask;
    end else begin
      write_value = cur & ~mask;
    end
  endfunction

  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] data_reg;
  logic rie_reg;
  logic arm_reg;
  logic [2:0] arm_cnt_reg;
  logic done_reg;
  logic [7:0] gpio_reg [3];
  logic [2:0] stall_cnt_reg;
  logic rd_load_reg;
  eac_state_type state_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic [ADDR_W-1:0] wa_reg;
  logic [7:0] wd_reg;
  logic rc_meta_reg;
  logic rc_sync_reg;
  logic rc_prev_reg;
  logic [7:0] mem_rdata;

  wire logic [6:0] acc = io_decode(io_space, io_addr);
  wire logic hit = acc[6];
  wire logic [5:0] idx = acc[5:0];
  wire logic bit_req = io_bit_set | io_bit_clr;
  wire logic bit_op = bit_req && io_space && hit && (idx <= `EAC_BIT_ACCESS_TOP);
  wire logic byte_wr = io_wr && hit && !bit_req;
  wire logic any_wr = byte_wr | bit_op;
  wire logic [7:0] mask = 8'h01 << io_bit;
  // bits a write sets to one; a bit op names only its own bit, so w1c neighbours stay untouched
  wire logic [7:0] ones = bit_op ? (io_bit_set ? mask : 8'h00) : io_wdata;
  wire logic busy = state_reg == EAC_PROG;

  wire logic ctl_wr = any_wr && (idx == `EAC_OFF_CONTROL);
  wire logic stat_wr = any_wr && (idx == `EAC_OFF_STATUS);
  wire logic data_wr = any_wr && (idx == `EAC_OFF_DATA);
  wire logic lo_wr = any_wr && (idx == `EAC_OFF_ADDR_LOW) && !busy;
  wire logic hi_wr = any_wr && (idx == `EAC_OFF_ADDR_HIGH) && !busy;

  wire logic [7:0] addr_lo = addr_reg[7:0];
  wire logic [7:0] addr_hi = {{(16 - ADDR_W){1'b0}}, addr_reg[ADDR_W-1:8]};
  wire logic [7:0] ctl_rd = {4'h0, rie_reg, arm_reg, busy, 1'b0};
  wire logic [7:0] stat_rd = {7'h00, done_reg};
  wire logic [7:0] ctl_new = write_value(ctl_rd, bit_op, io_bit_set, mask, io_wdata);
  wire logic [7:0] lo_new = write_value(addr_lo, bit_op, io_bit_set, mask, io_wdata);
  wire logic [7:0] hi_new = write_value(addr_hi, bit_op, io_bit_set, mask, io_wdata);
  wire logic [7:0] data_new = write_value(data_reg, bit_op, io_bit_set, mask, io_wdata);

  wire logic arm_set = ctl_wr && ones[`EAC_CTL_MASTER_WRITE_ARM];
  // arm must already be set; setting both in one write only arms, no write starts
  wire logic start = ctl_wr && ones[`EAC_CTL_WRITE_STROBE] && arm_reg && !busy
                     && !self_program_busy;
  wire logic read_go = ctl_wr && ones[`EAC_CTL_READ_STROBE] && !busy && !start;
  wire logic rc_rise = rc_sync_reg && !rc_prev_reg;
  wire logic fin = busy && rc_rise && (tick_cnt_reg == TW'(WRITE_TICKS - 1));

  wire logic [7:0] rd_mux =
    (idx == `EAC_OFF_ADDR_LOW) ? addr_lo :
    (idx == `EAC_OFF_ADDR_HIGH) ? addr_hi :
    (idx == `EAC_OFF_DATA) ? data_reg :
    (idx == `EAC_OFF_CONTROL) ? ctl_rd :
    (idx == `EAC_OFF_STATUS) ? stat_rd :
    (idx == `EAC_OFF_GPIO0) ? gpio_reg[0] :
    (idx == `EAC_OFF_GPIO1) ? gpio_reg[1] :
    (idx == `EAC_OFF_GPIO2) ? gpio_reg[2] : 8'h00;

  wire logic [5:0] gpio_off [3] = '{`EAC_OFF_GPIO0, `EAC_OFF_GPIO1, `EAC_OFF_GPIO2};
  wire logic mem_we = ce && fin;
  wire logic [ADDR_W-1:0] mem_addr = fin ? wa_reg : addr_reg;

  eac_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(ADDR_W)) u_mem (
    .mclk(mclk),
    .ce(ce),
    .we(mem_we),
    .re(read_go),
    .addr(mem_addr),
    .wdata(wd_reg),
    .rdata(mem_rdata)
  );

  // no reset: software must load an address before any access
  always_ff @(posedge mclk) begin
    if (ce && lo_wr) begin
      addr_reg[7:0] <= lo_new;
    end
    if (ce && hi_wr) begin
      addr_reg[ADDR_W-1:8] <= hi_new[ADDR_W-9:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= `EAC_RESET_BYTE;
      rd_load_reg <= 1'b0;
    end else if (ce) begin
      rd_load_reg <= read_go;
      if (rd_load_reg) begin
        data_reg <= mem_rdata;
      end else if (data_wr) begin
        data_reg <= data_new;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rie_reg <= 1'b0;
      arm_reg <= 1'b0;
      arm_cnt_reg <= 3'd0;
    end else if (ce) begin
      if (ctl_wr) begin
        rie_reg <= ctl_new[`EAC_CTL_READY_IRQ_ENABLE];
      end
      if (arm_set) begin
        arm_reg <= 1'b1;
        arm_cnt_reg <= 3'd0;
      end else if (arm_reg) begin
        arm_cnt_reg <= arm_cnt_reg + 3'd1;
        arm_reg <= arm_cnt_reg != (`EAC_ARM_CYCLES - 3'd1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else if (ce) begin
      // completion beats a clear in the same cycle
      if (fin) begin
        done_reg <= 1'b1;
      end else if (stat_wr && ones[`EAC_STAT_WRITE_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 3; k++) begin
        gpio_reg[k] <= `EAC_RESET_BYTE;
      end
    end else if (ce) begin
      for (int k = 0; k < 3; k++) begin
        if (any_wr && idx == gpio_off[k]) begin
          gpio_reg[k] <= write_value(gpio_reg[k], bit_op, io_bit_set, mask, io_wdata);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stall_cnt_reg <= 3'd0;
      cpu_stall <= 1'b0;
    end else if (ce) begin
      if (start) begin
        stall_cnt_reg <= `EAC_WRITE_STALL_CYCLES - 3'd1;
        cpu_stall <= 1'b1;
      end else if (read_go) begin
        stall_cnt_reg <= `EAC_READ_STALL_CYCLES - 3'd1;
        cpu_stall <= 1'b1;
      end else if (stall_cnt_reg != 3'd0) begin
        stall_cnt_reg <= stall_cnt_reg - 3'd1;
      end else begin
        cpu_stall <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
      ready_irq <= 1'b0;
    end else if (ce) begin
      io_rdata <= (io_rd && hit) ? rd_mux : 8'h00;
      ready_irq <= rie_reg && gie && !busy;
    end
  end

  // oscillator crosses in through two flops; edges are found from the second and a third flop that delays it
  always_ff @(posedge mclk or negedge npor) begin
    if (!npor) begin
      rc_meta_reg <= 1'b0;
      rc_sync_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end else if (ce) begin
      rc_meta_reg <= rc_clk;
      rc_sync_reg <= rc_meta_reg;
      rc_prev_reg <= rc_sync_reg;
    end
  end

  // the write engine answers only to power-on reset so a system reset cannot cut a write short
  always_ff @(posedge mclk or negedge npor) begin
    if (!npor) begin
      state_reg <= EAC_IDLE;
      tick_cnt_reg <= '0;
      wa_reg <= '0;
      wd_reg <= 8'h00;
    end else if (ce) begin
      case (state_reg)
        EAC_IDLE: begin
          if (start) begin
            state_reg <= EAC_PROG;
            tick_cnt_reg <= '0;
            wa_reg <= addr_reg;
            wd_reg <= data_reg;
          end
        end
        EAC_PROG: begin
          if (fin) begin
            state_reg <= EAC_IDLE;
          end else if (rc_rise) begin
            tick_cnt_reg <= tick_cnt_reg + TW'(1);
          end
        end
        default: begin
          state_reg <= EAC_IDLE;
        end
      endcase
    end
  end

  assign write_busy = state_reg[1];

  a_arm_hold: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    arm_set |=> arm_reg [*4]) else $error("master arm dropped early");
  a_arm_expire: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    arm_set ##1 (!arm_set) [*4] |=> !arm_reg) else $error("master arm did not expire");
  a_unarmed_ignored: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    (ctl_wr && ones[1] && !arm_reg && !busy) |=> !write_busy) else $error("write began unarmed");
  a_spm_blocks: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    (self_program_busy && !busy) |=> !write_busy) else $error("write began during self-program");
  a_write_stall: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    start |=> cpu_stall [*2] ##1 (!cpu_stall || $past(read_go))) else $error("write stall length wrong");
  a_read_stall: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    read_go |=> cpu_stall [*4]) else $error("read stall too short");
  a_read_data: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    read_go |-> ##2 data_reg == $past(u_mem.store[addr_reg[$clog2(DEPTH)-1:0]], 2))
    else $error("read byte not in data register");
  a_addr_frozen: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    (busy && $past(busy)) |-> $stable(addr_reg) && $stable(wa_reg)) else $error("address moved during write");
  a_no_read_busy: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    busy |-> !read_go) else $error("read accepted during write");
  a_irq_level: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    (rie_reg && gie && !busy) [*2] |-> ready_irq) else $error("ready irq missing");
  a_write_time: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    $fell(busy) |-> tick_cnt_reg == TW'(WRITE_TICKS - 1)) else $error("write ended early");
  a_done_w1c: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    (done_reg && !(stat_wr && ones[0])) |=> done_reg) else $error("done flag lost without clear");
  a_ctl_reserved: assert property (@(posedge mclk) disable iff (!nrst || !npor || !ce)
    (io_rd && hit && idx == `EAC_OFF_CONTROL) |=> io_rdata[7:4] == 4'h0) else $error("reserved bits set");
endmodule

// [dv/testbench.sv]
// self-checking bench for the nonvolatile access controller, driven through its io register port
`timescale 1ns/100ps
`include "eac_regs.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
  // short programming time so a write finishes in a few dozen cycles
  localparam int TICKS = 8;
  localparam int RC_HALF = 23;
  localparam logic [7:0] CTL = {2'b00, `EAC_OFF_CONTROL};
  localparam logic [7:0] ST = {2'b00, `EAC_OFF_STATUS};
  localparam logic [7:0] DAT = {2'b00, `EAC_OFF_DATA};
  localparam logic [7:0] AL = {2'b00, `EAC_OFF_ADDR_LOW};
  localparam logic [7:0] AH = {2'b00, `EAC_OFF_ADDR_HIGH};
  localparam logic [7:0] G0 = {2'b00, `EAC_OFF_GPIO0};
  localparam logic [7:0] G1 = {2'b00, `EAC_OFF_GPIO1};
  logic mclk = 1'b0, nrst = 1'b0, npor = 1'b0, ce = 1'b1, io_space = 1'b1, rc_clk = 1'b0;
  logic io_wr = 1'b0, io_rd = 1'b0, io_bit_set = 1'b0, io_bit_clr = 1'b0, gie = 1'b0, self_program_busy = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic [2:0] io_bit = 3'h0;
  logic [7:0] io_rdata;
  logic cpu_stall, ready_irq, write_busy;
  logic [7:0] rd_val;
  int err_total = 0;
  int n_compared = 0;
  int stalls;
  time t0;

  eac_top #(.WRITE_TICKS(TICKS)) i_dut (.mclk(mclk), .nrst(nrst), .npor(npor), .ce(ce), .io_space(io_space),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
    .io_bit(io_bit), .io_wdata(io_wdata), .gie(gie), .self_program_busy(self_program_busy), .rc_clk(rc_clk),
    .io_rdata(io_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq), .write_busy(write_busy));

  initial begin
    forever #4 mclk = ~mclk;
  end

  // oscillator free-runs with a period unrelated to mclk
  initial begin
    forever #RC_HALF rc_clk = ~rc_clk;
  end

  // kind 0 write, 1 read, 2 bit set, 3 bit clear; request held for one edge, n sample points counting that edge
  task automatic op(input int kind, input logic [7:0] a, input logic [7:0] d, input int n = 2);
    io_addr = a;
    io_wdata = d;
    io_bit = d[2:0];
    io_wr = (kind == 0);
    io_rd = (kind == 1);
    io_bit_set = (kind == 2);
    io_bit_clr = (kind == 3);
    stalls = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #1;
      if (i == 0) begin
        rd_val = io_rdata;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_bit_set = 1'b0;
        io_bit_clr = 1'b0;
      end
      if (cpu_stall === 1'b1) stalls++;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    op(1, a, 8'h00);
    `CHK(nm, exp, rd_val)
  endtask

  task automatic t_regs();
    rdc("control", CTL, 8'h00);
    rdc("data", DAT, 8'h00);
    op(0, AH, 8'hff);
    rdc("addr_high", AH, 8'h07);
    io_space = 1'b0;
    op(0, AL + 8'h20, 8'h3c);
    rdc("addr_low_ds", AL + 8'h20, 8'h3c);
    io_space = 1'b1;
    rdc("addr_low", AL, 8'h3c);
    op(0, G0, 8'ha5);
    op(2, G0, 8'h01);
    rdc("store0_set", G0, 8'ha7);
    op(3, G0, 8'h07);
    rdc("store0_clr", G0, 8'h27);
    // bit ops reach data space only as plain loads and stores, so this clear must be ignored
    io_space = 1'b0;
    op(3, G0 + 8'h20, 8'h00);
    io_space = 1'b1;
    rdc("store0_ds_bit", G0, 8'h27);
    op(0, G1, 8'h5a);
    op(2, G1, 8'h00);
    rdc("store1_noop", G1, 8'h5a);
    ce = 1'b0;
    op(0, G1, 8'h33);
    ce = 1'b1;
    rdc("store1_ce_low", G1, 8'h5a);
    rdc("unmapped", 8'h05, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_irq();
    op(0, CTL, 8'h08);
    gie = 1'b1;
    idle(2);
    `CHK("irq_on", 1'b1, ready_irq)
    gie = 1'b0;
    idle(2);
    `CHK("irq_gie_off", 1'b0, ready_irq)
    gie = 1'b1;
    $display("test irq done");
  endtask

  task automatic t_write();
    int k;
    time dt;
    op(0, AH, 8'h01);
    op(0, AL, 8'h23);
    op(0, DAT, 8'h5c);
    gie = 1'b0;
    op(0, CTL, 8'h0c);
    rdc("armed", CTL, 8'h0c);
    // strobe lands on the fourth edge after arming, the last one allowed
    op(0, CTL, 8'h0a, 8);
    t0 = $time - 64;
    gie = 1'b1;
    `CHK("write_stall", 2, stalls)
    `CHK("busy", 1'b1, write_busy)
    rdc("strobe_held", CTL, 8'h0a);
    `CHK("irq_busy", 1'b0, ready_irq)
    op(0, AL, 8'h77);
    rdc("addr_frozen", AL, 8'h23);
    op(0, DAT, 8'h11);
    nrst = 1'b0;
    idle(1);
    nrst = 1'b1;
    `CHK("busy_after_rst", 1'b1, write_busy)
    for (k = 0; k < 300 && write_busy !== 1'b0; k++) idle(1);
    dt = $time - t0;
    `CHK("busy_end", 1'b0, write_busy)
    `CHK("prog_time", 1'b1, dt >= (TICKS - 1) * 2 * RC_HALF && dt <= (TICKS + 3) * 2 * RC_HALF)
    rdc("done", ST, 8'h01);
    op(2, ST, 8'h03);
    rdc("done_bitop", ST, 8'h01);
    op(0, ST, 8'h00);
    rdc("done_w0", ST, 8'h01);
    op(0, ST, 8'h01);
    rdc("done_w1", ST, 8'h00);
    op(0, CTL, 8'h01, 8);
    `CHK("read_stall", 4, stalls)
    rdc("read_back", DAT, 8'h5c);
    $display("test write done");
  endtask

  task automatic t_refuse();
    op(0, CTL, 8'h04);
    idle(3);
    op(0, CTL, 8'h02);
    `CHK("late_strobe", 1'b0, write_busy)
    rdc("arm_cleared", CTL, 8'h00);
    self_program_busy = 1'b1;
    op(0, CTL, 8'h04);
    op(0, CTL, 8'h02);
    `CHK("spm_block", 1'b0, write_busy)
    self_program_busy = 1'b0;
    $display("test refuse done");
  endtask

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // whole run is under two hundred cycles; this cuts a hang
  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge mclk);
    #1;
    nrst = 1'b1;
    npor = 1'b1;
    idle(1);
    t_regs();
    t_irq();
    t_write();
    t_refuse();
    close_out();
  end
endmodule
